/* bench/radio_config_status_regs_test.sv */
`default_nettype none
`include "rcsr_consts.svh"

module radio_config_status_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rcsr_pkg::*;

  localparam logic [4:0] P_RX = 5'h10;
  localparam logic [4:0] P_TXD = 5'h08;
  localparam logic [4:0] P_ACK = 5'h04;
  localparam logic [4:0] P_FAIL = 5'h02;
  localparam logic [4:0] P_START = 5'h01;

  logic           clk;
  logic           reset;
  logic           sck;
  logic           csn;
  logic           mosi;
  logic           miso;
  logic           miso_oe;
  logic           miso_pin;
  logic           retx;
  logic           halt;
  logic           irq_n;
  logic           host_done;
  logic [15:0]    host_got;
  rcsr_radio_type radio;
  rcsr_cfg_type   cfg;
  logic [15:0]    exp_q[$];
  int             fails;
  int             check_count;
  int             seed;
  logic           bank;
  logic           rxf;
  logic           txf;
  logic           rtf;
  logic           full;
  logic [2:0]     pipe;
  logic [31:0]    v;

  rcsr_regs #(.STEP_CYCLES(4)) i_rcsr_regs
  (
    .CLK(clk), .RESET(reset), .SCK(sck), .CSN(csn), .MOSI(mosi),
    .MISO(miso), .MISO_OE(miso_oe), .RADIO(radio), .CFG(cfg),
    .RETRANSMIT(retx), .LINK_HALT(halt), .IRQ_N(irq_n)
  );

  // released data line shows the inverse of its last level
  assign miso_pin = miso_oe ? miso : !miso;

  rcsr_host i_rcsr_host
  (
    .clk(clk), .sck(sck), .csn(csn), .mosi(mosi), .miso(miso_pin),
    .done(host_done), .got(host_got)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // checking
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic compare_level(input string what, input logic [15:0] e,
                               input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic compare_frame(input logic [15:0] e, input logic [15:0] g);
    compare_level("status_and_data", e, g);
  endtask

  always @(posedge clk)
  begin
    if (host_done === 1'b1)
      compare_frame(exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX,
                    host_got);
  end

  // ==========================================================
  // stimulus helpers
  function automatic logic [7:0] st();
    st = {bank, rxf, txf, rtf, (pipe == 3'h6) ? 3'h7 : pipe, full};
  endfunction

  task automatic frame(input logic [7:0] c, input logic [7:0] d,
                       input logic [7:0] e);
    compare_level("miso_oe", 16'h0000, 16'(miso_oe));
    exp_q.push_back({st(), e});
    i_rcsr_host.xfer(c, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    frame({`RCSR_CMD_READ, a}, 8'h00, e);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    frame({`RCSR_CMD_WRITE, a}, d, 8'h00);
  endtask

  task automatic pulse(input logic [4:0] p);
    @(posedge clk);
    radio[12:8] <= p;
    @(posedge clk);
    radio[12:8] <= 5'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic await_retx(input int d);
    int k;
    pulse(P_FAIL);
    k = 0;
    while (retx !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 200)
    begin
      fails++;
      final_report();
    end
    compare_level("retx_wait", 16'h0001,
                  16'(k >= (d + 1) * 4 - 3 && k <= (d + 1) * 4 + 2));
    @(posedge clk);
    compare_level("retx_pulse", 16'h0000, 16'(retx));
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'hF225;
    fails = 0;
    check_count = 0;
    {bank, rxf, txf, rtf, full} = 5'h00;
    pipe = 3'h7;
    radio = '0;
    radio.rx_pipe = 3'h7;
    reset = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    rd(5'h03, 8'h03);
    rd(5'h04, 8'h03);
    rd(5'h05, 8'h02);
    rd(5'h06, 8'h3F);
    rd(5'h08, 8'h00);
    rd(5'h07, st());
    for (int i = 1; i < 4; i++)
    begin
      wr(5'h03, 8'(i));
      compare_level("width", 16'({2'(i), 5'h1F >> (3 - i)}),
                    16'({cfg.addr_width_code, cfg.addr_byte_en}));
    end
    wr(5'h03, 8'h00);
    rd(5'h03, 8'h03);
    wr(5'h03, 8'hFD);
    rd(5'h03, 8'h01);
    wr(5'h06, 8'h00);
    rd(5'h06, 8'h30);
    compare_level("radio", 16'h0000, 16'({cfg.air_rate_sel,
                  cfg.tx_power_sel, cfg.rx_gain_high}));
    wr(5'h06, 8'h0D);
    compare_level("radio", 16'h000D, 16'({cfg.air_rate_sel,
                  cfg.tx_power_sel, cfg.rx_gain_high}));
    repeat (3)
    begin
      v = $random(seed);
      wr(5'h05, {1'b0, v[6:0]});
      compare_level("chan", 16'(v[6:0]), 16'(cfg.channel_select));
      rd(5'h05, {1'b0, v[6:0]});
      wr(5'h04, v[15:8]);
      compare_level("retr", 16'(v[15:8]),
        16'({cfg.retransmit_delay, cfg.retransmit_limit}));
    end
    pulse(P_RX);
    rxf = 1'b1;
    compare_level("irq_n", 16'h0000, 16'(irq_n));
    radio.rx_ready_irq_mask <= 1'b1;
    repeat (3) @(posedge clk);
    compare_level("irq_n", 16'h0001, 16'(irq_n));
    radio.rx_ready_irq_mask <= 1'b0;
    pulse(P_TXD);
    txf = 1'b1;
    radio[2:1] <= 2'h3;
    repeat (3) @(posedge clk);
    compare_level("irq_n", 16'h0001, 16'(irq_n));
    radio[2:1] <= 2'h0;
    rd(5'h07, st());
    wr(5'h07, 8'h00);
    rd(5'h07, st());
    wr(5'h07, 8'h60);
    {rxf, txf} = 2'h0;
    radio.auto_ack <= 1'b1;
    pulse(P_TXD);
    rd(5'h07, st());
    pulse(P_ACK);
    txf = 1'b1;
    wr(5'h07, 8'h20);
    txf = 1'b0;
    rd(5'h07, st());
    radio.auto_ack <= 1'b0;
    radio.tx_fifo_full <= 1'b1;
    full = 1'b1;
    for (int p = 0; p < 8; p++)
    begin
      radio.rx_pipe <= 3'(p);
      pipe = 3'(p);
      rd(5'h07, st());
    end
    radio.tx_fifo_full <= 1'b0;
    full = 1'b0;
    wr(5'h04, 8'h21);
    pulse(P_START);
    await_retx(2);
    rd(5'h08, 8'h01);
    pulse(P_FAIL);
    rtf = 1'b1;
    compare_level("halt", 16'h0001, 16'(halt));
    compare_level("irq_n", 16'h0000, 16'(irq_n));
    radio.retry_limit_irq_mask <= 1'b1;
    repeat (3) @(posedge clk);
    compare_level("irq_n", 16'h0001, 16'(irq_n));
    radio.retry_limit_irq_mask <= 1'b0;
    rd(5'h08, 8'h11);
    pulse(P_START);
    rd(5'h08, 8'h10);
    wr(5'h07, 8'h10);
    rtf = 1'b0;
    compare_level("halt", 16'h0000, 16'(halt));
    wr(5'h05, 8'h02);
    rd(5'h08, 8'h00);
    wr(5'h04, 8'h00);
    repeat (17)
    begin
      pulse(P_FAIL);
      rtf = 1'b1;
      wr(5'h07, 8'h10);
      rtf = 1'b0;
    end
    wr(5'h08, 8'h00);
    rd(5'h08, 8'hF0);
    frame(`RCSR_CMD_BANK_SWITCH, `RCSR_BANK_KEY, 8'h00);
    bank = 1'b1;
    rd(5'h05, 8'h00);
    wr(5'h05, 8'h11);
    frame(`RCSR_CMD_BANK_SWITCH, `RCSR_BANK_KEY, 8'h00);
    bank = 1'b0;
    rd(5'h05, 8'h02);
    repeat (10) @(posedge clk);
    final_report();
  end
endmodule

`default_nettype wire

/* bench/rcsr_host.sv */
`default_nettype none

module rcsr_host
(
  // serial pins
  input  wire logic        clk,
  output logic             sck,
  output logic             csn,
  output logic             mosi,
  input  wire logic        miso,
  // captured frame
  output logic             done,
  output logic [15:0]      got
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sck = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
    done = 1'b0;
    got = 16'h0000;
  end

  // ==========================================================
  // one frame: command byte then one data byte, mode 0
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] o;
    logic [15:0] v;
    o = {c, d};
    v = 16'h0000;
    @(posedge clk);
    csn <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi <= o[i];
      repeat (6) @(posedge clk);
      sck <= 1'b1;
      v[i] = miso;
      repeat (6) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    csn <= 1'b1;
    // released data line must not keep its last level
    mosi <= ~mosi;
    got <= v;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* common/rcsr_consts.svh */
`ifndef RCSR_CONSTS_SVH
`define RCSR_CONSTS_SVH

// ==========================================================
// register offsets (bank 0)
`define RCSR_ADDR_WIDTH_SETUP 5'h03
`define RCSR_RETRANSMIT_SETUP 5'h04
`define RCSR_CHANNEL_SELECT   5'h05
`define RCSR_RADIO_SETUP      5'h06
`define RCSR_EVENT_STATUS     5'h07
`define RCSR_TRANSMIT_OBSERVE 5'h08

// ==========================================================
// command encodings
`define RCSR_CMD_READ         3'h0
`define RCSR_CMD_WRITE        3'h1
`define RCSR_CMD_BANK_SWITCH  8'h50
`define RCSR_BANK_KEY         8'h53
`define RCSR_CMD_NOP          8'hFF

// ==========================================================
// field positions
`define RCSR_BIT_RX_READY     6
`define RCSR_BIT_TX_SENT      5
`define RCSR_BIT_RETRY_LIMIT  4

// ==========================================================
// reset values
`define RCSR_RST_ADDR_WIDTH   2'h3
`define RCSR_RST_RETRANSMIT   8'h03
`define RCSR_RST_CHANNEL      7'h02
`define RCSR_RST_AIR_RATE     1'h1
`define RCSR_RST_TX_POWER     2'h3
`define RCSR_RST_RX_GAIN      1'h1
`define RCSR_RADIO_RSVD       4'h3
`define RCSR_PIPE_EMPTY       3'h7
`define RCSR_PIPE_UNUSED      3'h6

// ==========================================================
// timing
`define RCSR_CLK_MHZ          20
`define RCSR_RETR_STEP_US     250
`define RCSR_TIMER_W          17

`endif

/* common/rcsr_pkg.sv */
`default_nettype none
`include "rcsr_consts.svh"

package rcsr_pkg;

  typedef enum logic [1:0]
  {
    PH_IDLE = 2'b01,
    PH_WAIT = 2'b10
  } rcsr_phase_type;

  // ==========================================================
  // events and levels from the radio core
  typedef struct packed {
    logic       rx_payload;
    logic       tx_done;
    logic       ack_rcvd;
    logic       ack_fail;
    logic       tx_start;
    logic       auto_ack;
    logic       tx_fifo_full;
    logic [2:0] rx_pipe;
    logic       rx_ready_irq_mask;
    logic       tx_sent_irq_mask;
    logic       retry_limit_irq_mask;
  } rcsr_radio_type;

  // ==========================================================
  // configuration toward the radio core
  typedef struct packed {
    logic [1:0] addr_width_code;
    logic [4:0] addr_byte_en;
    logic [6:0] channel_select;
    logic       air_rate_sel;
    logic [1:0] tx_power_sel;
    logic       rx_gain_high;
    logic [3:0] retransmit_delay;
    logic [3:0] retransmit_limit;
  } rcsr_cfg_type;

  // ==========================================================
  // whole state of the register block
  typedef struct packed {
    logic                     sck_s1;
    logic                     sck_s2;
    logic                     sck_d;
    logic                     csn_s1;
    logic                     csn_s2;
    logic                     csn_d;
    logic                     mosi_s1;
    logic                     mosi_s2;
    logic [2:0]               bit_cnt;
    logic [1:0]               byte_idx;
    logic [7:0]               rx_sh;
    logic [7:0]               tx_sh;
    logic [7:0]               cmd;
    logic                     miso_oe;
    logic [1:0]               addr_width_code;
    logic [7:0]               retransmit_setup;
    logic [6:0]               channel_select;
    logic                     air_rate_sel;
    logic [1:0]               tx_power_sel;
    logic                     rx_gain_high;
    logic                     bank_indicator;
    logic                     rx_ready_flag;
    logic                     tx_sent_flag;
    logic                     retry_limit_flag;
    logic [3:0]               lost_packet_count;
    logic [3:0]               retry_count;
    rcsr_phase_type           phase;
    logic [`RCSR_TIMER_W-1:0] timer;
    logic                     retransmit;
    logic                     irq_n;
  } rcsr_state_type;

endpackage

`default_nettype wire

/* rtl/rcsr_regs.sv */
// What this block does
// - width code 01/10/11 gives 3/4/5 bytes
// - short addresses use low stored bytes
// - retransmit wait is 250 us steps
// - retransmit count caps retries, resets three
// - seven-bit channel, resets to two
// - air rate bit, 1 or 2 Mbps
// - two-bit power select, resets to 11
// - receiver gain bit, high when set
// - reserved bits hold zero, except radio setup bits 7:4 read 0011
// - status shifts out during command byte
// - bit 7 shows bank, toggled by key
// - receive-ready flag sets on new payload
// - sent flag sets on ack, or on send when auto-ack is off
// - event flags clear only by writing one
// - retry-limit flag halts further traffic
// - bits 3:1 give pipe, 111 when empty
// - bit 0 shows transmit FIFO full
// - lost counter saturates at fifteen
// - channel write clears lost counter
// - retry counter restarts with new packet
// - unmasked flags drive low interrupt pin
`default_nettype none
`include "rcsr_consts.svh"

module rcsr_regs
#(
  parameter int STEP_CYCLES = `RCSR_RETR_STEP_US * `RCSR_CLK_MHZ
)
(
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  // serial port pins
  input  wire logic                     SCK,
  input  wire logic                     CSN,
  input  wire logic                     MOSI,
  output logic                          MISO,
  output logic                          MISO_OE,
  // radio core
  input  wire rcsr_pkg::rcsr_radio_type RADIO,
  output var  rcsr_pkg::rcsr_cfg_type   CFG,
  output logic                          RETRANSMIT,
  output logic                          LINK_HALT,
  output logic                          IRQ_N
);
  import rcsr_pkg::*;

  if (STEP_CYCLES < 1 || 16 * STEP_CYCLES > 2 ** `RCSR_TIMER_W)
  begin : g_check
    $error("retransmit step does not fit the timer");
  end

  rcsr_state_type s;
  rcsr_state_type n;
  logic           sck_rise;
  logic           sck_fall;
  logic           csn_fall;
  logic           byte_done;
  logic [7:0]     rx_byte;
  logic           wr_en;
  logic           wr_chan;
  logic [7:0]     stat_now;

  // ==========================================================
  // helpers
  function automatic logic [4:0] addr_byte_en(input logic [1:0] code);
    unique case (code)
      2'h1:    addr_byte_en = 5'h07;
      2'h2:    addr_byte_en = 5'h0F;
      default: addr_byte_en = 5'h1F;
    endcase
  endfunction

  function automatic logic [`RCSR_TIMER_W-1:0] delay_cycles(
    input logic [3:0] code);
    delay_cycles = `RCSR_TIMER_W'((int'(code) + 1) * STEP_CYCLES - 1);
  endfunction

  function automatic logic [7:0] status_byte(input rcsr_state_type st,
                                             input rcsr_radio_type rd);
    logic [2:0] pipe;
    pipe = (rd.rx_pipe == `RCSR_PIPE_UNUSED) ? `RCSR_PIPE_EMPTY
                                             : rd.rx_pipe;
    status_byte = {st.bank_indicator, st.rx_ready_flag,
                   st.tx_sent_flag, st.retry_limit_flag,
                   pipe, rd.tx_fifo_full};
  endfunction

  function automatic logic [7:0] read_reg(input rcsr_state_type st,
                                          input logic [4:0]     a,
                                          input logic [7:0]     stat);
    read_reg = 8'h00;
    if (!st.bank_indicator)
    begin
      case (a)
        `RCSR_ADDR_WIDTH_SETUP: read_reg = {6'h00, st.addr_width_code};
        `RCSR_RETRANSMIT_SETUP: read_reg = st.retransmit_setup;
        `RCSR_CHANNEL_SELECT:   read_reg = {1'h0, st.channel_select};
        `RCSR_RADIO_SETUP:      read_reg = {`RCSR_RADIO_RSVD,
                                            st.air_rate_sel,
                                            st.tx_power_sel,
                                            st.rx_gain_high};
        `RCSR_EVENT_STATUS:     read_reg = stat;
        `RCSR_TRANSMIT_OBSERVE: read_reg = {st.lost_packet_count,
                                            st.retry_count};
        default:                read_reg = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // serial port decode
  assign sck_rise  = s.sck_s2 && !s.sck_d;
  assign sck_fall  = !s.sck_s2 && s.sck_d;
  assign csn_fall  = !s.csn_s2 && s.csn_d;
  assign byte_done = !s.csn_s2 && sck_rise && (s.bit_cnt == 3'h7);
  assign rx_byte   = {s.rx_sh[6:0], s.mosi_s2};
  assign wr_en     = byte_done && (s.byte_idx == 2'h1) &&
                     (s.cmd[7:5] == `RCSR_CMD_WRITE) && !s.bank_indicator;
  assign wr_chan   = wr_en && (s.cmd[4:0] == `RCSR_CHANNEL_SELECT);
  assign stat_now  = status_byte(s, RADIO);

  // ==========================================================
  // next state
  always_comb
  begin
    n            = s;
    n.sck_s1     = SCK;
    n.sck_s2     = s.sck_s1;
    n.sck_d      = s.sck_s2;
    n.csn_s1     = CSN;
    n.csn_s2     = s.csn_s1;
    n.csn_d      = s.csn_s2;
    n.mosi_s1    = MOSI;
    n.mosi_s2    = s.mosi_s1;
    n.retransmit = 1'b0;

    if (s.csn_s2)
      n.miso_oe = 1'b0;
    if (csn_fall)
    begin
      n.bit_cnt  = 3'h0;
      n.byte_idx = 2'h0;
      n.tx_sh    = stat_now;
      n.miso_oe  = 1'b1;
    end
    else if (!s.csn_s2 && sck_rise)
    begin
      n.rx_sh   = rx_byte;
      n.bit_cnt = s.bit_cnt + 3'h1;
    end
    else if (!s.csn_s2 && sck_fall && s.bit_cnt != 3'h0)
      n.tx_sh = {s.tx_sh[6:0], 1'b0};

    // byte boundaries: command, then one data byte
    if (byte_done)
    begin
      if (s.byte_idx == 2'h0)
      begin
        n.cmd      = rx_byte;
        n.byte_idx = 2'h1;
        n.tx_sh    = (rx_byte[7:5] == `RCSR_CMD_READ)
                     ? read_reg(s, rx_byte[4:0], stat_now) : 8'h00;
      end
      else
      begin
        n.byte_idx = 2'h2;
        if (s.byte_idx == 2'h1 && s.cmd == `RCSR_CMD_BANK_SWITCH &&
            rx_byte == `RCSR_BANK_KEY)
          n.bank_indicator = !s.bank_indicator;
      end
    end

    // register writes
    if (wr_en)
    begin
      case (s.cmd[4:0])
        `RCSR_ADDR_WIDTH_SETUP:
          if (rx_byte[1:0] != 2'h0)
            n.addr_width_code = rx_byte[1:0];
        `RCSR_RETRANSMIT_SETUP:
          n.retransmit_setup = rx_byte;
        `RCSR_CHANNEL_SELECT:
          n.channel_select = rx_byte[6:0];
        `RCSR_RADIO_SETUP:
        begin
          n.air_rate_sel = rx_byte[3];
          n.tx_power_sel = rx_byte[2:1];
          n.rx_gain_high = rx_byte[0];
        end
        `RCSR_EVENT_STATUS:
        begin
          if (rx_byte[`RCSR_BIT_RX_READY])
            n.rx_ready_flag = 1'b0;
          if (rx_byte[`RCSR_BIT_TX_SENT])
            n.tx_sent_flag = 1'b0;
          if (rx_byte[`RCSR_BIT_RETRY_LIMIT])
            n.retry_limit_flag = 1'b0;
        end
        default:
          n.cmd = s.cmd;
      endcase
    end
    if (wr_chan)
      n.lost_packet_count = 4'h0;

    // hardware sets come after clears so they win
    if (RADIO.rx_payload)
      n.rx_ready_flag = 1'b1;
    if (RADIO.ack_rcvd || (RADIO.tx_done && !RADIO.auto_ack))
      n.tx_sent_flag = 1'b1;

    // retransmission sequencing
    unique case (s.phase)
      PH_IDLE:
        if (RADIO.ack_fail && !s.retry_limit_flag)
        begin
          if (s.retry_count == s.retransmit_setup[3:0])
          begin
            n.retry_limit_flag = 1'b1;
            if (n.lost_packet_count != 4'hF)
              n.lost_packet_count = n.lost_packet_count + 4'h1;
          end
          else
          begin
            n.phase = PH_WAIT;
            n.timer = delay_cycles(s.retransmit_setup[7:4]);
          end
        end
      PH_WAIT:
        if (s.timer == `RCSR_TIMER_W'(0))
        begin
          n.phase       = PH_IDLE;
          n.retransmit  = 1'b1;
          n.retry_count = s.retry_count + 4'h1;
        end
        else
          n.timer = s.timer - `RCSR_TIMER_W'(1);
    endcase
    if (RADIO.tx_start)
    begin
      n.retry_count = 4'h0;
      n.phase       = PH_IDLE;
      n.timer       = `RCSR_TIMER_W'(0);
      n.retransmit  = 1'b0;
    end

    n.irq_n = !((n.rx_ready_flag && !RADIO.rx_ready_irq_mask) ||
                (n.tx_sent_flag && !RADIO.tx_sent_irq_mask) ||
                (n.retry_limit_flag &&
                 !RADIO.retry_limit_irq_mask));
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s                  <= '0;
      s.sck_s1           <= 1'b0;
      s.csn_s1           <= 1'b1;
      s.csn_s2           <= 1'b1;
      s.csn_d            <= 1'b1;
      s.addr_width_code  <= `RCSR_RST_ADDR_WIDTH;
      s.retransmit_setup <= `RCSR_RST_RETRANSMIT;
      s.channel_select   <= `RCSR_RST_CHANNEL;
      s.air_rate_sel     <= `RCSR_RST_AIR_RATE;
      s.tx_power_sel     <= `RCSR_RST_TX_POWER;
      s.rx_gain_high     <= `RCSR_RST_RX_GAIN;
      s.phase            <= PH_IDLE;
      s.irq_n            <= 1'b1;
    end
    else
      s <= n;
  end

  // ==========================================================
  // outputs
  assign MISO       = s.tx_sh[7];
  assign MISO_OE    = s.miso_oe;
  assign RETRANSMIT = s.retransmit;
  assign LINK_HALT  = s.retry_limit_flag;
  assign IRQ_N      = s.irq_n;
  assign CFG        = '{addr_width_code:  s.addr_width_code,
                        addr_byte_en:     addr_byte_en(s.addr_width_code),
                        channel_select:   s.channel_select,
                        air_rate_sel:     s.air_rate_sel,
                        tx_power_sel:     s.tx_power_sel,
                        rx_gain_high:     s.rx_gain_high,
                        retransmit_delay: s.retransmit_setup[7:4],
                        retransmit_limit: s.retransmit_setup[3:0]};

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  width_legal_a:
    assert property (s.addr_width_code != 2'h0)
    else $error("address width code is illegal");

  byte_enable_a:
    assert property (CFG.addr_byte_en[2:0] == 3'h7 &&
                     CFG.addr_byte_en[3] == (s.addr_width_code != 2'h1) &&
                     CFG.addr_byte_en[4] == (s.addr_width_code == 2'h3))
    else $error("address byte enables do not match width");

  retry_delay_a:
    assert property ($rose(s.phase == PH_WAIT) |->
                     s.timer == delay_cycles($past(s.retransmit_setup[7:4])))
    else $error("retransmit wait loaded with wrong length");

  wait_expiry_a:
    assert property ((s.phase == PH_WAIT && s.timer == `RCSR_TIMER_W'(0) &&
                      !RADIO.tx_start) |=> s.retransmit ##1 !s.retransmit)
    else $error("retransmit pulse missing at end of wait");

  limit_reach_a:
    assert property ($rose(s.retry_limit_flag) |->
                     $past(s.retry_count) == $past(s.retransmit_setup[3:0]))
    else $error("retry limit flag raised early");

  status_shift_a:
    assert property (csn_fall |=> s.tx_sh == $past(stat_now) && s.miso_oe)
    else $error("status not loaded at frame start");

  flag_hold_a:
    assert property ((s.rx_ready_flag && !wr_en) |=> s.rx_ready_flag)
    else $error("receive ready flag lost without a clear");

  rx_set_a:
    assert property (RADIO.rx_payload |=> s.rx_ready_flag)
    else $error("receive ready flag not set");

  tx_set_a:
    assert property (RADIO.ack_rcvd |=> s.tx_sent_flag)
    else $error("data sent flag not set on ack");

  lost_sat_a:
    assert property ((s.lost_packet_count == 4'hF && !wr_chan) |=>
                     s.lost_packet_count == 4'hF)
    else $error("lost counter wrapped");

  lost_clear_a:
    assert property ((wr_chan && !RADIO.ack_fail) |=>
                     s.lost_packet_count == 4'h0)
    else $error("lost counter kept after channel write");

  halt_hold_a:
    assert property (s.retry_limit_flag && s.phase == PH_IDLE |=>
                     !s.retransmit [*2])
    else $error("retransmission while halted");

  irq_level_a:
    assert property (##1 IRQ_N == !((s.rx_ready_flag &&
                     !$past(RADIO.rx_ready_irq_mask)) ||
                     (s.tx_sent_flag && !$past(RADIO.tx_sent_irq_mask)) ||
                     (s.retry_limit_flag &&
                      !$past(RADIO.retry_limit_irq_mask))))
    else $error("interrupt pin disagrees with flags");

endmodule

`default_nettype wire
